// ### design/estx_consts.vh
// Opcode, width and reset constants for the extended tail-group executor
`ifndef ESTX_CONSTS_VH
`define ESTX_CONSTS_VH
`define ESTX_OP_W 4
`define ESTX_OP_NIBBLE_EXCHANGE_TO_WORKING 4'h0
`define ESTX_OP_SKIP_IF_MEM_NULL 4'h1
`define ESTX_OP_SKIP_IF_MEM_NULL_WITH_COPY 4'h2
`define ESTX_OP_SKIP_IF_BIT_NULL 4'h3
`define ESTX_OP_PAGED_TABLE_FETCH 4'h4
`define ESTX_OP_FINAL_PAGE_TABLE_FETCH 4'h5
`define ESTX_OP_PREINC_PAGED_TABLE_FETCH 4'h6
`define ESTX_OP_PREINC_FINAL_PAGE_TABLE_FETCH 4'h7
`define ESTX_OP_EXCLUSIVE_OR_TO_WORKING 4'h8
`define ESTX_OP_EXCLUSIVE_OR_TO_MEMORY 4'h9
`define ESTX_DW 8
`define ESTX_MAW 9
`define ESTX_PAW 16
`define ESTX_PDW 16
`define ESTX_FINAL_PAGE 8'hFF
`define ESTX_NULL_BYTE 8'h00
`define ESTX_PTR_STEP 8'h01
`define ESTX_RST_BYTE 8'h00
`define ESTX_RST_WORD 16'h0000
`define ESTX_RST_MADDR 9'h000
`define ESTX_ST_IDLE 4'h1
`define ESTX_ST_ISSUE 4'h2
`define ESTX_ST_CAPTURE 4'h4
`define ESTX_ST_DUMMY 4'h8
`endif

// ### design/estx_exec.v
// Executor for swap, zero-test skip, table read and exclusive-or instructions
`timescale 1ns/1ps
`include "estx_consts.vh"

// Overview of operation
// - Swap memory nibbles into working register; memory and flags stay unchanged.
// - Byte zero test writes byte back unchanged, skips next when zero.
// - A taken skip inserts one dummy slot, four instruction slots in total.
// - Zero test with copy loads working register, skips when zero.
// - Bit zero test skips next instruction when selected bit is zero.
// - Paged table fetch addresses upper:lower pointer; low byte memory, high byte latch.
// - Final page fetch uses lower pointer on last page only.
// - Pre-increment lower pointer, then paged table fetch with new pointer.
// - Pre-increment lower pointer, then final page table fetch.
// - Exclusive-or into working register updates only the zero flag.
// - Exclusive-or into memory updates only the zero flag.
module estx_exec (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire start_i,
   input wire [`ESTX_OP_W-1:0] op_i,
   input wire [`ESTX_MAW-1:0] mem_addr_i,
   input wire [2:0] bit_sel_i,
   input wire [`ESTX_DW-1:0] working_i,
   input wire [`ESTX_DW-1:0] mem_rdata_i,
   input wire [`ESTX_PDW-1:0] pm_rdata_i,
   input wire tp_lower_wr_i,
   input wire tp_upper_wr_i,
   input wire [`ESTX_DW-1:0] tp_wdata_i,
   output reg busy_o,
   output reg mem_rd_o,
   output reg [`ESTX_MAW-1:0] mem_addr_o,
   output reg mem_wr_o,
   output reg [`ESTX_DW-1:0] mem_wdata_o,
   output reg working_wr_o,
   output reg [`ESTX_DW-1:0] working_wdata_o,
   output reg zero_wr_o,
   output reg zero_o,
   output reg pm_rd_o,
   output reg [`ESTX_PAW-1:0] pm_addr_o,
   output reg [`ESTX_DW-1:0] table_high_latch_o,
   output reg [`ESTX_DW-1:0] table_pointer_lower_o,
   output reg [`ESTX_DW-1:0] table_pointer_upper_o,
   output reg skip_o,
   output reg dummy_slot_o,
   output reg done_o
);
   localparam [3:0] ST_IDLE = `ESTX_ST_IDLE;
   localparam [3:0] ST_ISSUE = `ESTX_ST_ISSUE;
   localparam [3:0] ST_CAPTURE = `ESTX_ST_CAPTURE;
   localparam [3:0] ST_DUMMY = `ESTX_ST_DUMMY;

   reg rst_meta_r;
   reg rst_sync_r;
   reg [3:0] state_r;
   reg [`ESTX_OP_W-1:0] op_r;
   reg [2:0] bit_r;
   reg [`ESTX_DW-1:0] work_r;
   reg [`ESTX_DW-1:0] tp_lower_nxt;
   reg is_table;
   reg is_final;
   reg is_preinc;
   wire [`ESTX_DW-1:0] xor_val;
   wire [`ESTX_DW-1:0] rd_byte;

   assign xor_val = work_r ^ mem_rdata_i;
   assign rd_byte = mem_rdata_i;

   // Reset is released through two flops so every state flop sees a clean edge
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   always @* begin
      is_table = 1'b0;
      is_final = 1'b0;
      is_preinc = 1'b0;
      case (op_i)
         `ESTX_OP_PAGED_TABLE_FETCH: begin
            is_table = 1'b1;
         end
         `ESTX_OP_FINAL_PAGE_TABLE_FETCH: begin
            is_table = 1'b1;
            is_final = 1'b1;
         end
         `ESTX_OP_PREINC_PAGED_TABLE_FETCH: begin
            is_table = 1'b1;
            is_preinc = 1'b1;
         end
         `ESTX_OP_PREINC_FINAL_PAGE_TABLE_FETCH: begin
            is_table = 1'b1;
            is_final = 1'b1;
            is_preinc = 1'b1;
         end
         default: begin
            is_table = 1'b0;
         end
      endcase
      tp_lower_nxt = table_pointer_lower_o;
      if (is_preinc) begin
         tp_lower_nxt = table_pointer_lower_o + `ESTX_PTR_STEP;
      end
   end

   always @(posedge core_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= ST_IDLE;
         op_r <= {`ESTX_OP_W{1'b0}};
         bit_r <= 3'h0;
         work_r <= `ESTX_RST_BYTE;
         busy_o <= 1'b0;
         mem_rd_o <= 1'b0;
         mem_addr_o <= `ESTX_RST_MADDR;
         mem_wr_o <= 1'b0;
         mem_wdata_o <= `ESTX_RST_BYTE;
         working_wr_o <= 1'b0;
         working_wdata_o <= `ESTX_RST_BYTE;
         zero_wr_o <= 1'b0;
         zero_o <= 1'b0;
         pm_rd_o <= 1'b0;
         pm_addr_o <= `ESTX_RST_WORD;
         table_high_latch_o <= `ESTX_RST_BYTE;
         table_pointer_lower_o <= `ESTX_RST_BYTE;
         table_pointer_upper_o <= `ESTX_RST_BYTE;
         skip_o <= 1'b0;
         dummy_slot_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         working_wr_o <= 1'b0;
         zero_wr_o <= 1'b0;
         pm_rd_o <= 1'b0;
         skip_o <= 1'b0;
         dummy_slot_o <= 1'b0;
         done_o <= 1'b0;
         // Software loads take effect only while idle, so a fetch in flight keeps its pointer
         if (state_r == ST_IDLE) begin
            if (tp_lower_wr_i) begin
               table_pointer_lower_o <= tp_wdata_i;
            end
            if (tp_upper_wr_i) begin
               table_pointer_upper_o <= tp_wdata_i;
            end
         end
         case (state_r)
            ST_IDLE: begin
               if (start_i) begin
                  state_r <= ST_ISSUE;
                  busy_o <= 1'b1;
                  op_r <= op_i;
                  bit_r <= bit_sel_i;
                  work_r <= working_i;
                  mem_addr_o <= mem_addr_i;
                  if (is_table) begin
                     pm_rd_o <= 1'b1;
                     table_pointer_lower_o <= tp_lower_nxt;
                     if (is_final) begin
                        pm_addr_o <= {`ESTX_FINAL_PAGE, tp_lower_nxt};
                     end else begin
                        pm_addr_o <= {table_pointer_upper_o, tp_lower_nxt};
                     end
                  end else begin
                     mem_rd_o <= 1'b1;
                  end
               end
            end
            ST_ISSUE: begin
               state_r <= ST_CAPTURE;
            end
            ST_CAPTURE: begin
               state_r <= ST_IDLE;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               case (op_r)
                  `ESTX_OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                     working_wr_o <= 1'b1;
                     working_wdata_o <= {rd_byte[3:0], rd_byte[7:4]};
                  end
                  `ESTX_OP_SKIP_IF_MEM_NULL: begin
                     mem_wr_o <= 1'b1;
                     mem_wdata_o <= rd_byte;
                     if (rd_byte == `ESTX_NULL_BYTE) begin
                        skip_o <= 1'b1;
                        dummy_slot_o <= 1'b1;
                        done_o <= 1'b0;
                        busy_o <= 1'b1;
                        state_r <= ST_DUMMY;
                     end
                  end
                  `ESTX_OP_SKIP_IF_MEM_NULL_WITH_COPY: begin
                     working_wr_o <= 1'b1;
                     working_wdata_o <= rd_byte;
                     if (rd_byte == `ESTX_NULL_BYTE) begin
                        skip_o <= 1'b1;
                        dummy_slot_o <= 1'b1;
                        done_o <= 1'b0;
                        busy_o <= 1'b1;
                        state_r <= ST_DUMMY;
                     end
                  end
                  `ESTX_OP_SKIP_IF_BIT_NULL: begin
                     if (!rd_byte[bit_r]) begin
                        skip_o <= 1'b1;
                        dummy_slot_o <= 1'b1;
                        done_o <= 1'b0;
                        busy_o <= 1'b1;
                        state_r <= ST_DUMMY;
                     end
                  end
                  `ESTX_OP_PAGED_TABLE_FETCH, `ESTX_OP_FINAL_PAGE_TABLE_FETCH,
                  `ESTX_OP_PREINC_PAGED_TABLE_FETCH, `ESTX_OP_PREINC_FINAL_PAGE_TABLE_FETCH: begin
                     mem_wr_o <= 1'b1;
                     mem_wdata_o <= pm_rdata_i[7:0];
                     table_high_latch_o <= pm_rdata_i[15:8];
                  end
                  `ESTX_OP_EXCLUSIVE_OR_TO_WORKING: begin
                     working_wr_o <= 1'b1;
                     working_wdata_o <= xor_val;
                     zero_wr_o <= 1'b1;
                     zero_o <= (xor_val == `ESTX_NULL_BYTE);
                  end
                  `ESTX_OP_EXCLUSIVE_OR_TO_MEMORY: begin
                     mem_wr_o <= 1'b1;
                     mem_wdata_o <= xor_val;
                     zero_wr_o <= 1'b1;
                     zero_o <= (xor_val == `ESTX_NULL_BYTE);
                  end
                  default: begin
                     // Unknown opcodes complete with no side effect
                     done_o <= 1'b1;
                  end
               endcase
            end
            ST_DUMMY: begin
               // Dummy slot covers the discarded fetch of the skipped instruction
               state_r <= ST_IDLE;
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            default: begin
               state_r <= ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end
endmodule // estx_exec

// ### testbench/estx_exec_asserts.sv
// Checker for the tail-group executor ports
`timescale 1ns/1ps
`include "estx_consts.vh"
module estx_exec_asserts (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire start_i,
   input wire [3:0] op_i,
   input wire [2:0] bit_sel_i,
   input wire [7:0] working_i,
   input wire [7:0] mem_rdata_i,
   input wire [15:0] pm_rdata_i,
   input wire busy_o,
   input wire mem_wr_o,
   input wire [7:0] mem_wdata_o,
   input wire working_wr_o,
   input wire [7:0] working_wdata_o,
   input wire zero_wr_o,
   input wire zero_o,
   input wire pm_rd_o,
   input wire [15:0] pm_addr_o,
   input wire [7:0] table_high_latch_o,
   input wire [7:0] table_pointer_lower_o,
   input wire [7:0] table_pointer_upper_o,
   input wire skip_o,
   input wire dummy_slot_o,
   input wire done_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence take_s(logic [3:0] op);
      start_i && ce_i && !busy_o && op_i == op;
   endsequence
   sequence skip_tail_s;
      dummy_slot_o && busy_o ##1 done_o && !busy_o;
   endsequence
   // Sampled history instead of local variables keeps these portable to free simulators
   property swap_p;
      take_s(4'h0) |-> ##3 working_wr_o && !mem_wr_o && !zero_wr_o && done_o
         && working_wdata_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])};
   endproperty
   property skip_p(logic [3:0] op, bit cp);
      take_s(op) |-> ##3 !zero_wr_o && skip_o == ($past(mem_rdata_i) == 8'h00)
         && (cp ? working_wr_o && working_wdata_o == $past(mem_rdata_i)
            : mem_wr_o && mem_wdata_o == $past(mem_rdata_i));
   endproperty
   property bit_p;
      take_s(4'h3) |-> ##3 !zero_wr_o && !mem_wr_o && !working_wr_o
         && skip_o == ((($past(mem_rdata_i) >> $past(bit_sel_i, 3)) & 8'h01) == 8'h00);
   endproperty
   property tbl_p(logic [3:0] op, bit fp, logic [7:0] inc);
      take_s(op) |-> ##1 pm_rd_o && table_pointer_upper_o == $past(table_pointer_upper_o)
         && table_pointer_lower_o == $past(table_pointer_lower_o) + inc
         && pm_addr_o == {fp ? 8'hFF : $past(table_pointer_upper_o), $past(table_pointer_lower_o) + inc};
   endproperty
   property store_p;
      pm_rd_o |-> ##2 mem_wr_o && mem_wdata_o == $past(pm_rdata_i[7:0])
         && table_high_latch_o == $past(pm_rdata_i[15:8]);
   endproperty
   property xor_p(logic [3:0] op, bit tm);
      take_s(op) |-> ##3 zero_wr_o && zero_o == (($past(working_i, 3) ^ $past(mem_rdata_i)) == 8'h00)
         && (tm ? mem_wr_o && mem_wdata_o == ($past(working_i, 3) ^ $past(mem_rdata_i))
            : working_wr_o && working_wdata_o == ($past(working_i, 3) ^ $past(mem_rdata_i)));
   endproperty
   swap_nibbles_a: assert property (swap_p)
      else $error("nibble swap wrong");
   zero_writeback_a: assert property (skip_p(4'h1, 1'b0))
      else $error("byte test wrong");
   skip_dummy_a: assert property (skip_o |-> skip_tail_s)
      else $error("skip slot wrong");
   copy_skip_a: assert property (skip_p(4'h2, 1'b1))
      else $error("copy test wrong");
   bit_skip_a: assert property (bit_p)
      else $error("bit test wrong");
   paged_fetch_a: assert property (tbl_p(4'h4, 1'b0, 8'h00))
      else $error("paged address wrong");
   final_fetch_a: assert property (tbl_p(4'h5, 1'b1, 8'h00))
      else $error("final page address wrong");
   preinc_paged_a: assert property (tbl_p(4'h6, 1'b0, 8'h01))
      else $error("preinc paged wrong");
   preinc_final_a: assert property (tbl_p(4'h7, 1'b1, 8'h01))
      else $error("preinc final wrong");
   table_store_a: assert property (store_p)
      else $error("table word store wrong");
   xor_working_a: assert property (xor_p(4'h8, 1'b0))
      else $error("xor to working wrong");
   xor_memory_a: assert property (xor_p(4'h9, 1'b1))
      else $error("xor to memory wrong");
endmodule // estx_exec_asserts
bind estx_exec estx_exec_asserts i_estx_exec_asserts (.*);

// ### testbench/tb_top.sv
// Random self-checking bench for the tail-group executor
`timescale 1ns/1ps
`include "estx_consts.vh"
module tb_top;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, start_i = 1'b0, tp_lower_wr_i = 1'b0, tp_upper_wr_i = 1'b0;
   logic [3:0] op_i = 4'h0;
   logic [8:0] mem_addr_i = 9'h000;
   logic [2:0] bit_sel_i = 3'h0;
   logic [7:0] working_i = 8'h00, mem_rdata_i = 8'h00, tp_wdata_i = 8'h00, lo = 8'h00, hi = 8'h00, th = 8'h00;
   logic [15:0] pm_rdata_i = 16'h0000;
   wire busy_o, mem_rd_o, mem_wr_o, working_wr_o, zero_wr_o, zero_o, pm_rd_o, skip_o, dummy_slot_o, done_o;
   wire [8:0] mem_addr_o;
   wire [7:0] mem_wdata_o, working_wdata_o, table_high_latch_o, table_pointer_lower_o, table_pointer_upper_o;
   wire [15:0] pm_addr_o;
   int n_errors = 0;
   int total_checks = 0;
   int i;
   estx_exec i_estx_exec (.*);
   always #2.5 core_clk_i = ~core_clk_i;
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic load(input logic [7:0] l, input logic [7:0] u);
      @(negedge core_clk_i);
      {tp_lower_wr_i, tp_wdata_i} = {1'b1, l};
      @(negedge core_clk_i);
      {tp_lower_wr_i, tp_upper_wr_i, tp_wdata_i} = {2'b01, u};
      @(negedge core_clk_i);
      tp_upper_wr_i = 1'b0;
      {lo, hi} = {l, u};
   endtask
   // Clock enable low must hold every flop, even with a start and pointer loads pending
   task automatic freeze();
      @(negedge core_clk_i);
      {ce_i, start_i, tp_lower_wr_i, tp_upper_wr_i, tp_wdata_i} = {4'b0111, ~lo};
      repeat (3) @(negedge core_clk_i);
      chk({busy_o, pm_rd_o, mem_rd_o, table_pointer_lower_o, table_pointer_upper_o}, {3'h0, lo, hi});
      {ce_i, start_i, tp_lower_wr_i, tp_upper_wr_i} = 4'b1000;
   endtask
   function automatic logic skip_exp(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b);
      return (op == 4'h1 || op == 4'h2) ? m == 8'h00 : op == 4'h3 && !m[b];
   endfunction
   function automatic logic [7:0] swap_exp(input logic [7:0] m);
      return {m[3:0], m[7:4]};
   endfunction
   task automatic run(input logic [3:0] op, input logic [7:0] w, input logic [7:0] m);
      logic [15:0] pw;
      logic [7:0] xr;
      logic [2:0] b;
      logic [8:0] gw, gm, ew, em;
      logic [16:0] ga, ea;
      logic [1:0] gz, ez;
      logic gs, es, tb, rq, pq;
      int n;
      pw = 16'($urandom);
      b = 3'($urandom);
      xr = w ^ m;
      tb = op[3:2] == 2'b01;
      {gw, gm, ga, gz, gs, rq, pq} = '0;
      es = skip_exp(op, m, b);
      ew = op == 4'h0 ? {1'b1, swap_exp(m)} : op == 4'h2 ? {1'b1, m} : op == 4'h8 ? {1'b1, xr} : 9'h000;
      em = op == 4'h1 ? {1'b1, m} : op == 4'h9 ? {1'b1, xr} : tb ? {1'b1, pw[7:0]} : 9'h000;
      ez = (op == 4'h8 || op == 4'h9) ? {1'b1, xr == 8'h00} : 2'h0;
      lo = tb ? lo + op[1] : lo;
      ea = tb ? {1'b1, op[0] ? 8'hFF : hi, lo} : 17'h00000;
      th = tb ? pw[15:8] : th;
      @(negedge core_clk_i);
      {start_i, op_i, working_i, bit_sel_i, tp_wdata_i} = {1'b1, op, w, b, 8'($urandom)};
      mem_addr_i = 9'($urandom);
      mem_rdata_i = ~m;
      pm_rdata_i = ~pw;
      // Start and pointer load held into the busy cycle: both must be ignored
      for (n = 0; n < 8 && done_o !== 1'b1; n++) begin
         @(negedge core_clk_i);
         start_i = n == 0;
         tp_lower_wr_i = n == 0;
         gw = working_wr_o ? {1'b1, working_wdata_o} : gw;
         gm = mem_wr_o ? {1'b1, mem_wdata_o} : gm;
         gz = zero_wr_o ? {1'b1, zero_o} : gz;
         ga = pm_rd_o ? {1'b1, pm_addr_o} : ga;
         gs = gs | skip_o;
         // Read data valid in the strobe cycle and in the cycle after it
         mem_rdata_i = (mem_rd_o || rq) ? m : ~m;
         pm_rdata_i = (pm_rd_o || pq) ? pw : ~pw;
         {rq, pq} = {mem_rd_o, pm_rd_o};
      end
      chk(n, es ? 4 : 3);
      chk(gs, es);
      chk(gw, ew);
      chk(gm, em);
      chk(mem_addr_o, mem_addr_i);
      chk(gz, ez);
      chk(ga, ea);
      chk({table_high_latch_o, table_pointer_upper_o, table_pointer_lower_o}, {th, hi, lo});
   endtask
   initial begin
      void'($urandom(14));
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      load(8'hFF, 8'h5A);
      for (i = 0; i < 32; i++)
         run(4'(i), 8'(i * 37), i < 16 ? 8'h00 : 8'hFF);
      for (i = 0; i < 400; i++) begin
         if (i % 50 == 0) begin
            load(8'($urandom), 8'($urandom));
            freeze();
         end
         run(4'($urandom), 8'($urandom), $urandom % 3 == 0 ? 8'h00 : 8'($urandom));
      end
      end_sim();
   end
   initial begin
      #40000;
      n_errors++;
      end_sim();
   end
endmodule // tb_top
